/* File: hw/msm_mapper.sv */
// Purpose: map a multistate value onto six adjacent relay points
// Assumes: button inputs synchronous and already debounced
// Notes:   bus loss is a missing write to the value or kick register in time
// How it works
// RQ1: up-down: stage k turns on points n..n+k-1, none at zero
// RQ2: binary: value bit i drives point n+i, values 0 to 63
// RQ3: bus loss applies backup: all off, fixed pattern, or keep last
// RQ4: backup and mapping settings act at once while running
// RQ5: each point's status led follows its relay, except while flashing on error
// RQ6: on error the module led and point leds flash
// RQ7: middle press toggles local override on and off
// RQ8: plus press raises stage by one, saturates at highest stage
// RQ9: minus press lowers stage by one, stops at stage zero
// RQ10: override stage applied only after 0.3 s stable selection
// RQ11: override leds blank briefly while a button is pressed
// RQ12: a setting disables local operation; presses then ignored
// RQ13: outside logic inserts any all-off step between stages
// RQ14: unmapped value flags fault quality and applies backup
// RQ15: a control bit selects up-down or binary mapping
// RQ16: active override stage replaces the bus value as source
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module msm_mapper #(
    parameter int POINTS      = 6,
    parameter int SETTLE_CYC  = msm_pkg::SETTLE_CYC,
    parameter int BUS_TMO_CYC = msm_pkg::BUS_TMO_CYC,
    parameter int FLASH_CYC   = msm_pkg::FLASH_CYC,
    parameter int BLINK_CYC   = msm_pkg::BLINK_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        btn_mid,
    input  wire logic        btn_plus,
    input  wire logic        btn_minus,
    output var  logic [5:0]  relay_out,
    output var  logic [5:0]  point_led,
    output var  logic [5:0]  override_led,
    output var  logic        module_led,
    output var  logic        fault_quality,
    output var  logic        irq
);
    if (POINTS != 6) begin : g_bad_points
        $error("msm_mapper: only six points supported");
    end

    // ----------------------------------------------------------------
    // apb slave and registers
    // ----------------------------------------------------------------
    logic [3:0]  ctrl_r;
    logic [5:0]  multistate_out_value_r;
    logic [5:0]  backup_r;
    logic [msm_pkg::IRQ_W-1:0] irq_stat_r;
    logic [msm_pkg::IRQ_W-1:0] irq_mask_r;
    logic [msm_pkg::IRQ_W-1:0] irq_ev;
    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;
    logic [31:0] rd_nxt;
    logic        bus_lost;
    logic        map_fault;
    logic        ovr_r;
    logic [5:0]  sel_stage_r;
    logic [5:0]  act_stage_r;
    logic [5:0]  keep_r;
    logic [5:0]  relay_nxt;
    logic        err;

    assign wr_en    = psel && penable && pwrite;
    assign rd_en    = psel && penable && !pwrite;

    always_comb begin
        addr_ok = 1'b1;
        rd_nxt  = '0;
        unique case (paddr)
            msm_pkg::ADDR_CTRL:     rd_nxt[3:0] = ctrl_r;
            msm_pkg::ADDR_VALUE:    rd_nxt[5:0] = multistate_out_value_r;
            msm_pkg::ADDR_BACKUP:   rd_nxt[5:0] = backup_r;
            msm_pkg::ADDR_OUTPUTS:  rd_nxt[5:0] = relay_out;
            msm_pkg::ADDR_STATUS:   rd_nxt[15:0] = {2'h0, act_stage_r,
                5'h00, map_fault, bus_lost, ovr_r};
            msm_pkg::ADDR_IRQ_STAT: rd_nxt[msm_pkg::IRQ_W-1:0] = irq_stat_r;
            msm_pkg::ADDR_IRQ_MASK: rd_nxt[msm_pkg::IRQ_W-1:0] = irq_mask_r;
            msm_pkg::ADDR_BUS_KICK: rd_nxt = '0;
            default:                addr_ok = 1'b0;
        endcase
    end

    // zero wait state: pready is high in every access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            if (psel && !penable && !pwrite)
                prdata <= rd_nxt;
        end
    end

    // config written any time, used the very next cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r                 <= msm_pkg::CTRL_RESET;
            multistate_out_value_r <= '0;
            backup_r               <= '0;
            irq_mask_r             <= '0;
        end else if (wr_en && pready) begin
            unique case (paddr)
                msm_pkg::ADDR_CTRL:     ctrl_r <= pwdata[3:0]; // RQ4
                msm_pkg::ADDR_VALUE:
                    multistate_out_value_r <= pwdata[5:0];
                msm_pkg::ADDR_BACKUP:   backup_r <= pwdata[5:0]; // RQ4
                msm_pkg::ADDR_IRQ_MASK:
                    irq_mask_r <= pwdata[msm_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // bus supervision
    // ----------------------------------------------------------------
    logic bus_busy;
    logic bus_done;
    logic bus_kick;
    logic bus_lost_r;

    assign bus_kick = wr_en && pready &&
        (paddr == msm_pkg::ADDR_VALUE || paddr == msm_pkg::ADDR_BUS_KICK);

    msm_timer #(.W(32), .COUNT(BUS_TMO_CYC)) u_bus_tmo (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (bus_kick),
        .busy    (bus_busy),
        .done    (bus_done)
    );

    // lost until the first value or kick write; outputs start in backup state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            bus_lost_r <= 1'b1;
        else if (bus_kick)
            bus_lost_r <= 1'b0;
        else if (bus_done)
            bus_lost_r <= 1'b1;
    end
    assign bus_lost = bus_lost_r && !bus_busy;

    // ----------------------------------------------------------------
    // local override
    // ----------------------------------------------------------------
    logic mid_d;
    logic plus_d;
    logic minus_d;
    logic any_btn;
    logic local_ok;
    logic mid_ev;
    logic step_up;
    logic step_dn;
    logic rep_done;
    logic set_done;
    logic stage_chg;
    logic [5:0] stage_max;

    assign local_ok = !ctrl_r[msm_pkg::CTRL_LOCAL_DIS]; // RQ12
    assign any_btn  = btn_mid || btn_plus || btn_minus;
    assign mid_ev   = local_ok && btn_mid && !mid_d; // RQ7
    assign stage_max = ctrl_r[msm_pkg::CTRL_KIND] ? 6'h3f : 6'h06;

    // held button repeats at the blink interval
    msm_timer #(.W(32), .COUNT(BLINK_CYC)) u_rep (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (step_up || step_dn),
        .busy    (),
        .done    (rep_done)
    );

    assign step_up = local_ok && ovr_r && btn_plus && !btn_minus &&
        ((!plus_d) || rep_done);
    assign step_dn = local_ok && ovr_r && btn_minus && !btn_plus &&
        ((!minus_d) || rep_done);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mid_d   <= 1'b0;
            plus_d  <= 1'b0;
            minus_d <= 1'b0;
        end else begin
            mid_d   <= btn_mid;
            plus_d  <= btn_plus;
            minus_d <= btn_minus;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ovr_r <= 1'b0;
        else if (!local_ok)
            ovr_r <= 1'b0;
        else if (mid_ev)
            ovr_r <= !ovr_r; // RQ7
    end

    // entering override starts from the stage now applied
    assign stage_chg = step_up || step_dn;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            sel_stage_r <= '0;
        else if (!ovr_r)
            sel_stage_r <= multistate_out_value_r;
        else if (step_up && sel_stage_r < stage_max)
            sel_stage_r <= sel_stage_r + 6'h01; // RQ8
        else if (step_dn && sel_stage_r != 6'h00)
            sel_stage_r <= sel_stage_r - 6'h01; // RQ9
    end

    msm_timer #(.W(32), .COUNT(SETTLE_CYC)) u_settle (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (stage_chg),
        .busy    (),
        .done    (set_done)
    );

    // intermediate stages are skipped: only the settled one lands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            act_stage_r <= '0;
        else if (!ovr_r)
            act_stage_r <= sel_stage_r;
        else if (set_done)
            act_stage_r <= sel_stage_r; // RQ10
    end

    // ----------------------------------------------------------------
    // mapping and backup
    // ----------------------------------------------------------------
    function automatic logic [5:0] map_stage(
        input logic       binary,
        input logic [5:0] stage
    );
        logic [5:0] m;
        m = '0;
        if (binary)
            m = stage; // RQ2
        else
            for (int i = 0; i < 6; i++)
                m[i] = (6'(i) < stage); // RQ1
        return m;
    endfunction : map_stage

    logic [5:0] src_stage;
    assign src_stage = ovr_r ? act_stage_r : multistate_out_value_r; // RQ16
    // up-down has no entry above six; binary covers every code
    assign map_fault = !ovr_r && !ctrl_r[msm_pkg::CTRL_KIND] &&
        multistate_out_value_r > 6'h06; // RQ14

    always_comb begin
        relay_nxt = map_stage(ctrl_r[msm_pkg::CTRL_KIND], src_stage); // RQ15
        if ((bus_lost && !ovr_r) || map_fault) begin
            unique case (ctrl_r[msm_pkg::CTRL_BK_HI:msm_pkg::CTRL_BK_LO])
                msm_pkg::MSM_BK_VALUE: relay_nxt = backup_r; // RQ3
                msm_pkg::MSM_BK_KEEP:  relay_nxt = keep_r; // RQ3
                default:               relay_nxt = '0; // RQ3
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            keep_r <= '0;
        else if (!bus_lost && !map_fault)
            keep_r <= relay_nxt;
    end

    // ----------------------------------------------------------------
    // outputs and leds
    // ----------------------------------------------------------------
    logic flash_busy;
    logic flash_done;
    logic flash_r;

    msm_timer #(.W(32), .COUNT(FLASH_CYC)) u_flash (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (!flash_busy),
        .busy    (flash_busy),
        .done    (flash_done)
    );

    assign err = map_fault || bus_lost;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_r       <= 1'b0;
            relay_out     <= '0;
            point_led     <= '0;
            override_led  <= '0;
            module_led    <= 1'b0;
            fault_quality <= 1'b0;
        end else begin
            if (flash_done)
                flash_r <= !flash_r;
            relay_out     <= relay_nxt;
            fault_quality <= map_fault; // RQ14
            if (err) begin
                point_led  <= {6{flash_r}}; // RQ6
                module_led <= flash_r; // RQ6
            end else begin
                point_led  <= relay_nxt; // RQ5
                module_led <= 1'b1;
            end
            override_led <= (ovr_r && !(any_btn && local_ok)) ?
                6'h3f : 6'h00; // RQ11
        end
    end

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    logic bus_lost_d;
    logic fault_d;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_lost_d <= 1'b0;
            fault_d    <= 1'b0;
        end else begin
            bus_lost_d <= bus_lost;
            fault_d    <= map_fault;
        end
    end

    always_comb begin
        irq_ev = '0;
        irq_ev[msm_pkg::IRQ_BUS_LOST]  = bus_lost && !bus_lost_d;
        irq_ev[msm_pkg::IRQ_MAP_FAULT] = map_fault && !fault_d;
        irq_ev[msm_pkg::IRQ_OVR_TOG]   = mid_ev;
    end

    // set wins over a same-cycle write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= '0;
            irq        <= 1'b0;
        end else begin
            if (wr_en && pready && paddr == msm_pkg::ADDR_IRQ_STAT)
                irq_stat_r <= (irq_stat_r &
                    ~pwdata[msm_pkg::IRQ_W-1:0]) | irq_ev;
            else
                irq_stat_r <= irq_stat_r | irq_ev;
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end
endmodule : msm_mapper
`default_nettype wire

/* File: hw/msm_pkg.sv */
// Purpose: constants for the multistate stage output mapper
// Assumes: 50 MHz pclk, APB with 32-bit data
// Notes:   offsets are byte addresses
package msm_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_VALUE    = 8'h04;
    localparam logic [7:0] ADDR_BACKUP   = 8'h08;
    localparam logic [7:0] ADDR_OUTPUTS  = 8'h0c;
    localparam logic [7:0] ADDR_STATUS   = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
    localparam logic [7:0] ADDR_BUS_KICK = 8'h1c;

    // ----------------------------------------------------------------
    // control fields
    // ----------------------------------------------------------------
    localparam int CTRL_KIND      = 0;
    localparam int CTRL_LOCAL_DIS = 1;
    localparam int CTRL_BK_LO     = 2;
    localparam int CTRL_BK_HI     = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // ----------------------------------------------------------------
    // interrupt status bits
    // ----------------------------------------------------------------
    localparam int IRQ_BUS_LOST  = 0;
    localparam int IRQ_MAP_FAULT = 1;
    localparam int IRQ_OVR_TOG   = 2;
    localparam int IRQ_W         = 3;

    typedef enum logic [1:0] {
        MSM_BK_OFF   = 2'h0,
        MSM_BK_VALUE = 2'h1,
        MSM_BK_KEEP  = 2'h2
    } msm_backup_t;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ       = 50_000_000;
    localparam int SETTLE_MS    = 300;
    localparam int SETTLE_CYC   = CLK_HZ / 1000 * SETTLE_MS;
    localparam int BUS_TMO_MS   = 1000;
    localparam int BUS_TMO_CYC  = CLK_HZ / 1000 * BUS_TMO_MS;
    localparam int FLASH_MS     = 250;
    localparam int FLASH_CYC    = CLK_HZ / 1000 * FLASH_MS;
    localparam int BLINK_MS     = 100;
    localparam int BLINK_CYC    = CLK_HZ / 1000 * BLINK_MS;
endpackage : msm_pkg

/* File: hw/msm_timer.sv */
// Purpose: retriggerable down-counter, done pulse on expiry
// Assumes: load restarts the count
// Notes:   busy stays high while counting
`timescale 1ns/1ps
`default_nettype none
module msm_timer #(
    parameter int W     = 32,
    parameter int COUNT = 16
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic load,
    output var  logic busy,
    output var  logic done
);
    // count minus one must fit the counter width
    if (COUNT < 1 || $clog2(COUNT) > W) begin : g_bad_count
        $error("msm_timer: COUNT out of range");
    end

    logic [W-1:0] cnt_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (load) begin
                cnt_r <= W'(COUNT - 1);
                busy  <= 1'b1;
            end else if (busy) begin
                if (cnt_r == '0) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - 1'b1;
                end
            end
        end
    end
endmodule : msm_timer
`default_nettype wire

/* File: tb/msm_bus_model.sv */
// Purpose: bus master model writing process values over APB
// Assumes: transfers start one edge after the call
// Notes:   released lines carry inverted data, not the last value
`timescale 1ns/1ps
`default_nettype none
module msm_bus_model (
    input  wire logic        pclk,
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [7:0]  paddr,
    output var  logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // ----------------------------------------------------------------
    // transfers
    // ----------------------------------------------------------------
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer

    // caller inserts any all-off stage itself; no forced off here
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        xfer(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] q,
                      output logic e);
        xfer(1'b0, a, 32'h0, q, e);
    endtask : rd
endmodule : msm_bus_model
`default_nettype wire

/* File: tb/msm_mapper_sva.sv */
// Purpose: port checks for msm_mapper
// Assumes: one pclk domain, presetn async active low
// Notes:   flash bounds sized for a short flash count
`timescale 1ns/1ps
`default_nettype none
module msm_mapper_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        btn_mid,
    input wire logic        btn_plus,
    input wire logic        btn_minus,
    input wire logic [5:0]  relay_out,
    input wire logic [5:0]  point_led,
    input wire logic [5:0]  override_led,
    input wire logic        module_led,
    input wire logic        fault_quality,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire btn_any = btn_mid | btn_plus | btn_minus;

    // ----------------------------------------------------------------
    // bus answers
    // ----------------------------------------------------------------
    a_apb_answer: assert property (psel && !penable |=> pready)
        else $error("no ready one cycle after setup");
    a_ready_phase: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("slave error without ready");
    a_err_rdata: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returns data");

    // ----------------------------------------------------------------
    // leds and override
    // ----------------------------------------------------------------
    a_led_follow: assert property (
        point_led == relay_out || point_led == {6{module_led}})
        else $error("point led differs from relay");
    a_err_flash: assert property (
        fault_quality |-> ##[0:12] (!module_led || !fault_quality))
        else $error("module led not flashing on fault");
    a_press_blank: assert property (
        btn_any [*2] |-> override_led == 6'h00)
        else $error("override leds lit during press");
    a_ovr_uniform: assert property (
        override_led == 6'h00 || override_led == 6'h3f)
        else $error("override leds not all alike");
    a_settle_hold: assert property (
        $rose(btn_plus) && override_led == 6'h3f |=> $stable(relay_out)[*8])
        else $error("stage applied before settle");

    c_fault: cover property ($rose(fault_quality));
    c_plus_ovr: cover property (btn_plus && override_led == 6'h3f);
    c_refused: cover property (pslverr);
endmodule : msm_mapper_chk

bind msm_mapper msm_mapper_chk i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .btn_mid(btn_mid),
    .btn_plus(btn_plus), .btn_minus(btn_minus), .relay_out(relay_out),
    .point_led(point_led), .override_led(override_led),
    .module_led(module_led), .fault_quality(fault_quality), .irq(irq)
);
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: self-checking bench for msm_mapper
// Assumes: shortened counts set through parameters
// Notes:   random values from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int SETTLE = 20;
    localparam int TMO    = 50;
    localparam int BLINK  = 8;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic        btn_mid, btn_plus, btn_minus, module_led, fault_quality;
    logic        irq, rerr;
    logic [5:0]  relay_out, point_led, override_led, v, pat;
    int          err_total, n_checks, cyc;

    msm_mapper #(.SETTLE_CYC(SETTLE), .BUS_TMO_CYC(TMO), .FLASH_CYC(4),
        .BLINK_CYC(BLINK)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .btn_mid(btn_mid),
        .btn_plus(btn_plus), .btn_minus(btn_minus), .relay_out(relay_out),
        .point_led(point_led), .override_led(override_led),
        .module_led(module_led), .fault_quality(fault_quality), .irq(irq));
    msm_bus_model i_bus (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [5:0] exp_map(logic bin, logic [5:0] s);
        if (bin)
            return s;
        return (6'h01 << s) - 6'h01;
    endfunction : exp_map

    task automatic chk(string what, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (e !== g) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic tick(int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    // buttons as {mid, plus, minus}, held n cycles
    task automatic btn(logic [2:0] b, int n);
        {btn_mid, btn_plus, btn_minus} <= b;
        tick(n);
        {btn_mid, btn_plus, btn_minus} <= 3'h0;
        tick(1);
    endtask : btn

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // hang guard, well above the few hundred cycles needed
    initial cyc = 0;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            $display("timeout");
            finish_test();
        end
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        {btn_mid, btn_plus, btn_minus} = 3'h0;
        err_total = 0;
        n_checks = 0;
        void'($urandom(32'he992));
        tick(8);
        presetn <= 1'b1;
        chk("relay_rst", 32'h0, relay_out);
        i_bus.rd(8'h20, rdv, rerr);
        chk("slverr", 32'h1, rerr);
        chk("rd_unmapped", 32'h0, rdv);
        i_bus.rd(msm_pkg::ADDR_CTRL, rdv, rerr);
        chk("ctrl_rst", 32'h0, rdv);
        $display("test reset done");

        i_bus.wr(msm_pkg::ADDR_CTRL, 32'h0);
        for (int k = 0; k <= 6; k++) begin
            i_bus.wr(msm_pkg::ADDR_VALUE, k);
            tick(4);
            chk("updown", exp_map(1'b0, 6'(k)), relay_out);
            chk("point_led", exp_map(1'b0, 6'(k)), point_led);
        end
        i_bus.wr(msm_pkg::ADDR_CTRL, 32'h1);
        for (int i = 0; i < 14; i++) begin
            v = (i == 0) ? 6'h3f : (i == 1) ? 6'h00 : 6'($urandom_range(63));
            i_bus.wr(msm_pkg::ADDR_VALUE, {26'h0, v});
            tick(4);
            chk("binary", exp_map(1'b1, v), relay_out);
        end
        i_bus.rd(msm_pkg::ADDR_OUTPUTS, rdv, rerr);
        chk("outputs", {26'h0, v}, rdv);
        $display("test mapping done");

        pat = 6'($urandom_range(63));
        i_bus.wr(msm_pkg::ADDR_BACKUP, {26'h0, pat});
        i_bus.wr(msm_pkg::ADDR_IRQ_MASK, 32'h0);
        i_bus.wr(msm_pkg::ADDR_CTRL, 32'h4);
        i_bus.wr(msm_pkg::ADDR_VALUE, 32'h9);
        tick(4);
        chk("fault_q", 32'h1, fault_quality);
        chk("fault_bk", {26'h0, pat}, relay_out);
        chk("irq_masked", 32'h0, irq);
        i_bus.rd(msm_pkg::ADDR_IRQ_STAT, rdv, rerr);
        chk("stat_fault", 32'h1, rdv[1]);
        i_bus.wr(msm_pkg::ADDR_IRQ_MASK, 32'h2);
        tick(3);
        chk("irq_on", 32'h1, irq);
        i_bus.wr(msm_pkg::ADDR_VALUE, 32'h3);
        i_bus.wr(msm_pkg::ADDR_IRQ_STAT, 32'h2);
        tick(3);
        chk("irq_clr", 32'h0, irq);
        chk("fault_clr", 32'h0, fault_quality);
        $display("test fault done");

        i_bus.wr(msm_pkg::ADDR_CTRL, 32'h8);
        i_bus.wr(msm_pkg::ADDR_VALUE, 32'h5);
        tick(TMO + 10);
        chk("keep", 32'h1f, relay_out);
        i_bus.rd(msm_pkg::ADDR_STATUS, rdv, rerr);
        chk("bus_lost", 32'h1, rdv[1]);
        i_bus.wr(msm_pkg::ADDR_CTRL, 32'h0);
        tick(4);
        chk("bk_off", 32'h0, relay_out);
        i_bus.wr(msm_pkg::ADDR_CTRL, 32'h4);
        tick(4);
        chk("bk_pat", {26'h0, pat}, relay_out);
        $display("test bus loss done");

        i_bus.wr(msm_pkg::ADDR_CTRL, 32'h0);
        i_bus.wr(msm_pkg::ADDR_VALUE, 32'h2);
        tick(4);
        btn(3'h4, 1);
        i_bus.rd(msm_pkg::ADDR_STATUS, rdv, rerr);
        chk("ovr_on", 32'h1, rdv[0]);
        btn(3'h2, 1);
        tick(2);
        btn(3'h2, 1);
        tick(5);
        chk("settling", 32'h3, relay_out);
        tick(SETTLE + 4);
        chk("stage4", 32'h0f, relay_out);
        btn(3'h2, 8 * BLINK);
        tick(SETTLE + 4);
        chk("sat_hi", 32'h3f, relay_out);
        chk("ovr_led", 32'h3f, override_led);
        i_bus.rd(msm_pkg::ADDR_STATUS, rdv, rerr);
        chk("stage_hi", 32'h6, rdv[13:8]);
        btn(3'h1, 10 * BLINK);
        tick(SETTLE + 4);
        chk("sat_lo", 32'h0, relay_out);
        btn(3'h4, 1);
        i_bus.wr(msm_pkg::ADDR_BUS_KICK, 32'h0);
        tick(4);
        chk("ovr_exit", 32'h3, relay_out);
        $display("test override done");

        i_bus.wr(msm_pkg::ADDR_CTRL, 32'h2);
        btn(3'h4, 1);
        btn(3'h2, 2);
        i_bus.rd(msm_pkg::ADDR_STATUS, rdv, rerr);
        chk("local_dis", 32'h0, rdv[0]);
        i_bus.wr(msm_pkg::ADDR_VALUE, 32'h2);
        tick(SETTLE + 4);
        chk("dis_relay", 32'h3, relay_out);
        $display("test local disable done");
        finish_test();
    end
endmodule : testbench
`default_nettype wire
